/* core/sli_pkg.sv */
/*
 * constants, field layout and shared helpers of the split limit and
 * interrupt discovery register bank.
 * assumes one clock domain and configuration accesses of one word each.
 */
package sli_pkg;
	// ***************************************************************
	// register map
	// ***************************************************************
	localparam logic [7:0]  OFF_SPLIT     = 8'hac;
	localparam logic [7:0]  OFF_HDR       = 8'hb8;
	localparam logic [7:0]  OFF_DATA      = 8'hbc;
	localparam logic [7:0]  IDX_ENTRY_LO  = 8'h10;
	localparam logic [7:0]  IDX_ENTRY_HI  = 8'h11;
	// ***************************************************************
	// fixed values
	// ***************************************************************
	localparam logic [7:0]  CAP_TYPE      = 8'h80;
	localparam logic [7:0]  CAP_ID        = 8'h08;
	localparam logic [7:0]  NXT_LINK      = 8'hc0;
	localparam logic [7:0]  NXT_HOTPLUG   = 8'h90;
	localparam logic [7:0]  NXT_END       = 8'h00;
	localparam logic [15:0] LIMIT_RST     = 16'hffff;
	localparam logic [15:0] RESP_CAPACITY = 16'h0010;
	localparam logic [7:0]  INDEX_RST     = 8'h00;
	localparam logic [63:0] ENTRY_RST     = 64'h0000_0000_f800_0001;
	// ***************************************************************
	// entry layout
	// ***************************************************************
	localparam int          PEND_BIT      = 63;
	localparam int          PASS_POSTED_WRITES_FLAG_BIT    = 62;
	localparam logic [63:0] ENTRY_RW_MASK = 64'h40ff_ffff_ffff_ffff;
	localparam logic [55:0] INFO_MASK     = 56'hff_ffff_ffff_fffc;
	// ***************************************************************
	// answer sequencing of a configuration access
	// ***************************************************************
	typedef enum logic [0:0] {
		CFG_IDLE = 1'b0,
		CFG_ANS  = 1'b1
	} sli_cfg_state_t;

	// byte-lane merge of a write into a stored word
	function automatic logic [31:0] sli_merge(input logic [31:0] old_v,
			input logic [31:0] new_v, input logic [3:0] be);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction
endpackage

/* core/sli_read_throttle.sv */
/*
 * holds back downstream read requests while the outstanding count has
 * reached the free upstream buffer count.
 * assumes done pulses only for reads that were granted.
 */
`timescale 1ns/100ps
`default_nettype none
module sli_read_throttle (
	input  wire logic        clk_i,
	input  wire logic        arst_n_i,
	input  wire logic        req_i,
	input  wire logic        done_i,
	input  wire logic [15:0] free_i,
	output var  logic        grant_o
);
	import sli_pkg::*;
	logic [15:0] outst_r;
	logic        ok;

	assign ok = req_i && (outst_r < free_i);

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			grant_o <= 1'b0;
		end else begin
			grant_o <= ok;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			outst_r <= 16'h0000;
		end else if (ok && !done_i) begin
			outst_r <= outst_r + 16'h0001;
		end else if (!ok && done_i && outst_r != 16'h0000) begin
			outst_r <= outst_r - 16'h0001;
		end
	end

	AST_GRANT_CAP: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		grant_o |-> $past(outst_r) < $past(free_i))
		else $error("read granted with no free upstream buffer");
endmodule
`default_nettype wire

/* core/sli_redirect_entry.sv */
/*
 * the one physical redirection entry, written from the discovery window
 * and from the interrupt controller's own alias.
 * assumes the controller already translates its message type encoding.
 */
`timescale 1ns/100ps
`default_nettype none
module sli_redirect_entry (
	input  wire logic        clk_i,
	input  wire logic        arst_n_i,
	input  wire logic        win_we_i,
	input  wire logic        win_hi_i,
	input  wire logic [3:0]  win_be_i,
	input  wire logic [31:0] win_wdata_i,
	input  wire logic        ctl_we_i,
	input  wire logic        ctl_hi_i,
	input  wire logic [3:0]  ctl_be_i,
	input  wire logic [31:0] ctl_wdata_i,
	input  wire logic        pend_set_i,
	input  wire logic        pend_clr_i,
	output var  logic [63:0] entry_o
);
	import sli_pkg::*;
	logic [63:0] stor_r;
	logic [63:0] stor_nxt;
	logic        pend_r;
	logic        win_clr;

	// both paths land in one store; window wins a same-cycle collision
	always_comb begin
		stor_nxt = stor_r;
		if (ctl_we_i) begin
			if (ctl_hi_i) stor_nxt[63:32] = sli_merge(stor_r[63:32], ctl_wdata_i, ctl_be_i);
			else stor_nxt[31:0] = sli_merge(stor_r[31:0], ctl_wdata_i, ctl_be_i);
		end
		if (win_we_i) begin
			if (win_hi_i) stor_nxt[63:32] = sli_merge(stor_nxt[63:32], win_wdata_i, win_be_i);
			else stor_nxt[31:0] = sli_merge(stor_nxt[31:0], win_wdata_i, win_be_i);
		end
		stor_nxt = stor_nxt & ENTRY_RW_MASK;
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			stor_r <= ENTRY_RST & ENTRY_RW_MASK;
		end else begin
			stor_r <= stor_nxt;
		end
	end

	// pending bit: the window clears it by writing one, pend_clr_i clears it too; pend_set_i wins
	assign win_clr = win_we_i && win_hi_i && win_be_i[3] && win_wdata_i[31];

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pend_r <= ENTRY_RST[PEND_BIT];
		end else if (pend_set_i) begin
			pend_r <= 1'b1;
		end else if (pend_clr_i || win_clr) begin
			pend_r <= 1'b0;
		end
	end

	assign entry_o = {pend_r, stor_r[62:0]};

	AST_PEND_W1C: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		win_clr && !pend_set_i |=> !pend_r)
		else $error("pending bit survived a write of one");
	AST_PEND_CTL: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		pend_r && !pend_clr_i && !win_clr |=> pend_r)
		else $error("pending bit lost without a clearing cause");
endmodule
`default_nettype wire

/* core/sli_regs.sv */
/*
 * configuration registers of one bridge function: downstream split word,
 * interrupt discovery header and data port, and the packet field outputs.
 * assumes single-cycle configuration strobes, answered one cycle later.
 */
`timescale 1ns/100ps
`default_nettype none
module sli_regs #(
	parameter bit SECOND_BRIDGE = 1'b0
) (
	input  wire logic        CLK_SYS_I,
	input  wire logic        ARST_N_I,
	// configuration access
	input  wire logic        CFG_RD_I,
	input  wire logic        CFG_WR_I,
	input  wire logic [7:0]  CFG_ADDR_I,
	input  wire logic [3:0]  CFG_BE_I,
	input  wire logic [31:0] CFG_WDATA_I,
	output var  logic        CFG_ACK_O,
	output var  logic [31:0] CFG_RDATA_O,
	// hot plug enables of the two bridges
	input  wire logic        HOTPLUG_ENABLE_FIRST_BRIDGE_I,
	input  wire logic        HOTPLUG_ENABLE_SECOND_BRIDGE_I,
	// interrupt controller alias of the entry
	input  wire logic        CTL_WR_I,
	input  wire logic        CTL_HI_I,
	input  wire logic [3:0]  CTL_BE_I,
	input  wire logic [31:0] CTL_WDATA_I,
	output var  logic [63:0] CTL_ENTRY_O,
	input  wire logic        REMOTE_REQUEST_PENDING_SET_I,
	input  wire logic        REMOTE_REQUEST_PENDING_CLR_I,
	// interrupt packet fields
	output var  logic [55:0] PACKET_INFO_BITS_O,
	output var  logic        PASS_POSTED_WRITES_FLAG_O,
	output var  logic        POLARITY_BIT_O,
	output var  logic        INTERRUPT_MASK_BIT_O,
	// downstream read throttle
	input  wire logic        DS_READ_REQ_I,
	input  wire logic        DS_READ_DONE_I,
	input  wire logic [15:0] UP_BUF_FREE_I,
	output var  logic        DS_READ_GRANT_O
);
	import sli_pkg::*;

	// ***************************************************************
	// state
	// ***************************************************************
	logic [15:0]    commit_limit_r;
	logic [7:0]     index_r;
	logic [63:0]    entry;
	logic [7:0]     next_ptr;
	logic [31:0]    rd_word;
	logic           hit_split;
	logic           hit_hdr;
	logic           hit_data;
	logic           win_we;
	logic [31:0]    split_merged;
	sli_cfg_state_t cfg_state_r;
	sli_cfg_state_t cfg_state_nxt;

	// which half of the entry an index value names, or none
	function automatic logic [1:0] entry_half(input logic [7:0] idx);
		entry_half = {idx == IDX_ENTRY_HI, idx == IDX_ENTRY_LO};
	endfunction

	// ***************************************************************
	// address decode
	// ***************************************************************
	assign hit_split = CFG_ADDR_I == OFF_SPLIT;
	assign hit_hdr   = CFG_ADDR_I == OFF_HDR;
	assign hit_data  = CFG_ADDR_I == OFF_DATA;
	assign win_we    = CFG_WR_I && hit_data && (entry_half(index_r) != 2'b00);
	assign split_merged = sli_merge({commit_limit_r, RESP_CAPACITY}, CFG_WDATA_I, CFG_BE_I);

	// ***************************************************************
	// software held fields
	// ***************************************************************
	// the limit is only stored and read back; throttling ignores it
	always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			commit_limit_r <= LIMIT_RST;
		end else if (CFG_WR_I && hit_split) begin
			commit_limit_r <= split_merged[31:16];
		end
	end

	always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			index_r <= INDEX_RST;
		end else if (CFG_WR_I && hit_hdr && CFG_BE_I[2]) begin
			index_r <= CFG_WDATA_I[23:16];
		end
	end

	// ***************************************************************
	// next capability pointer
	// ***************************************************************
	always_comb begin
		if (SECOND_BRIDGE) begin
			next_ptr = HOTPLUG_ENABLE_SECOND_BRIDGE_I ? NXT_HOTPLUG : NXT_END;
		end else begin
			next_ptr = HOTPLUG_ENABLE_FIRST_BRIDGE_I ? NXT_HOTPLUG : NXT_LINK;
		end
	end

	// ***************************************************************
	// shared entry
	// ***************************************************************
	sli_redirect_entry u_entry (
		.clk_i       (CLK_SYS_I),
		.arst_n_i    (ARST_N_I),
		.win_we_i    (win_we),
		.win_hi_i    (entry_half(index_r) == 2'b10),
		.win_be_i    (CFG_BE_I),
		.win_wdata_i (CFG_WDATA_I),
		.ctl_we_i    (CTL_WR_I),
		.ctl_hi_i    (CTL_HI_I),
		.ctl_be_i    (CTL_BE_I),
		.ctl_wdata_i (CTL_WDATA_I),
		.pend_set_i  (REMOTE_REQUEST_PENDING_SET_I),
		.pend_clr_i  (REMOTE_REQUEST_PENDING_CLR_I),
		.entry_o     (entry)
	);

	// ***************************************************************
	// read mux
	// ***************************************************************
	always_comb begin
		rd_word = 32'h0000_0000;
		if (hit_split) begin
			rd_word = {commit_limit_r, RESP_CAPACITY};
		end else if (hit_hdr) begin
			rd_word = {CAP_TYPE, index_r, next_ptr, CAP_ID};
		end else if (hit_data) begin
			case (entry_half(index_r))
				2'b01:   rd_word = entry[31:0];
				2'b10:   rd_word = entry[63:32];
				default: rd_word = 32'h0000_0000;
			endcase
		end
	end

	// ***************************************************************
	// answer sequencing
	// ***************************************************************
	always_comb begin
		case (cfg_state_r)
			CFG_IDLE: cfg_state_nxt = (CFG_RD_I || CFG_WR_I) ? CFG_ANS : CFG_IDLE;
			CFG_ANS:  cfg_state_nxt = (CFG_RD_I || CFG_WR_I) ? CFG_ANS : CFG_IDLE;
			default:  cfg_state_nxt = CFG_IDLE;
		endcase
	end

	always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			cfg_state_r <= CFG_IDLE;
		end else begin
			cfg_state_r <= cfg_state_nxt;
		end
	end

	always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			CFG_ACK_O   <= 1'b0;
			CFG_RDATA_O <= 32'h0000_0000;
		end else begin
			CFG_ACK_O   <= CFG_RD_I || CFG_WR_I;
			CFG_RDATA_O <= CFG_RD_I ? rd_word : 32'h0000_0000;
		end
	end

	// ***************************************************************
	// packet fields and controller view
	// ***************************************************************
	always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			PACKET_INFO_BITS_O        <= ENTRY_RST[55:0] & INFO_MASK;
			PASS_POSTED_WRITES_FLAG_O <= ENTRY_RST[PASS_POSTED_WRITES_FLAG_BIT];
			POLARITY_BIT_O            <= ENTRY_RST[1];
			INTERRUPT_MASK_BIT_O      <= ENTRY_RST[0];
			CTL_ENTRY_O               <= ENTRY_RST;
		end else begin
			PACKET_INFO_BITS_O        <= entry[55:0] & INFO_MASK;
			PASS_POSTED_WRITES_FLAG_O <= entry[PASS_POSTED_WRITES_FLAG_BIT];
			POLARITY_BIT_O            <= entry[1];
			INTERRUPT_MASK_BIT_O      <= entry[0];
			CTL_ENTRY_O               <= entry;
		end
	end

	// ***************************************************************
	// downstream read throttle
	// ***************************************************************
	sli_read_throttle u_throttle (
		.clk_i    (CLK_SYS_I),
		.arst_n_i (ARST_N_I),
		.req_i    (DS_READ_REQ_I),
		.done_i   (DS_READ_DONE_I),
		.free_i   (UP_BUF_FREE_I),
		.grant_o  (DS_READ_GRANT_O)
	);

	// ***************************************************************
	// checks
	// ***************************************************************
	AST_LIMIT_STORE: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
		CFG_WR_I && hit_split && CFG_BE_I == 4'hf ##1 CFG_RD_I && hit_split
		|=> CFG_RDATA_O[31:16] == $past(CFG_WDATA_I[31:16], 2))
		else $error("commitment limit did not read back");
	AST_CAPACITY_RO: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
		CFG_RD_I && hit_split |=> CFG_ACK_O && CFG_RDATA_O[15:0] == RESP_CAPACITY)
		else $error("capacity field not constant");
	AST_HDR_FIXED: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
		CFG_RD_I && hit_hdr |=> CFG_RDATA_O[31:24] == CAP_TYPE
		&& CFG_RDATA_O[7:0] == CAP_ID)
		else $error("header fixed fields wrong");
	AST_NEXT_PTR: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
		CFG_RD_I && hit_hdr && !SECOND_BRIDGE |=> CFG_RDATA_O[15:8]
		== ($past(HOTPLUG_ENABLE_FIRST_BRIDGE_I) ? NXT_HOTPLUG : NXT_LINK))
		else $error("first bridge next pointer wrong");
	AST_INDEX_SEL: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
		CFG_WR_I && hit_hdr && CFG_BE_I[2] && CFG_WDATA_I[23:16] == IDX_ENTRY_LO
		##1 CFG_RD_I && hit_data |=> CFG_RDATA_O == $past(entry[31:0]))
		else $error("index did not select the entry low half");
	AST_PKT_INFO: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
		##1 PACKET_INFO_BITS_O[23:8] == $past(entry[23:8])
		&& PACKET_INFO_BITS_O[1:0] == 2'b00)
		else $error("packet info does not follow the entry");
	AST_NEXT_PTR_B: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
		CFG_RD_I && hit_hdr && SECOND_BRIDGE |=> CFG_RDATA_O[15:8]
		== ($past(HOTPLUG_ENABLE_SECOND_BRIDGE_I) ? NXT_HOTPLUG : NXT_END))
		else $error("second bridge next pointer wrong");
	AST_INDEX_HOLD: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
		!(CFG_WR_I && hit_hdr) |=> index_r == $past(index_r))
		else $error("index changed without a header write");
	AST_DATA_REFUSED: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
		CFG_RD_I && hit_data && entry_half(index_r) == 2'b00
		|=> CFG_RDATA_O == 32'h0000_0000)
		else $error("data port answered at an unmapped index");
	AST_CTL_VIEW: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
		CTL_ENTRY_O == $past(entry))
		else $error("controller view does not follow the entry");
	AST_PASS_POSTED_WRITES_FLAG: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
		PASS_POSTED_WRITES_FLAG_O == $past(entry[PASS_POSTED_WRITES_FLAG_BIT]))
		else $error("pass posted writes flag does not follow the entry");
	AST_INFO_HI: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
		PACKET_INFO_BITS_O[55:24] == $past(entry[55:24]))
		else $error("upper packet info does not follow the entry");
	AST_INFO_LO: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
		PACKET_INFO_BITS_O[7:2] == $past(entry[7:2]))
		else $error("mode and type packet bits do not follow the entry");
	AST_POL_MASK: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
		{POLARITY_BIT_O, INTERRUPT_MASK_BIT_O} == $past(entry[1:0]))
		else $error("polarity or mask does not follow the entry");
	AST_RESERVED: assert property (@(posedge CLK_SYS_I) disable iff (!ARST_N_I)
		entry[61:56] == 6'h00)
		else $error("reserved entry bits not zero");
endmodule
`default_nettype wire

/* verification/test_sli_regs.sv */
/*
 * self-checking bench of the split limit and interrupt discovery registers.
 * assumes one-cycle config strobes answered one cycle later, as in sli_regs.
 */
`timescale 1ns/100ps
`default_nettype none
module test_sli_regs;
	import sli_pkg::*;
	logic        clk = 1'b0;
	logic        arst_n = 1'b0;
	logic        rd_s = 1'b0, wr_s = 1'b0, ctl_wr = 1'b0, ctl_hi = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [3:0]  be = 4'h0, ctl_be = 4'h0;
	logic [31:0] wdata = 32'h0, ctl_wdata = 32'h0;
	logic        hp_a = 1'b0, hp_b = 1'b0, pend_set = 1'b0, pend_clr = 1'b0;
	logic        req = 1'b0, done = 1'b0;
	logic [15:0] free = 16'h0000;
	logic        ack, ack2, grant, pass_posted_writes_flag, polarity_bit, mask;
	logic [31:0] rdata, rdata2, q;
	logic [63:0] ctl_entry;
	logic [55:0] info;
	int          miscompares = 0;
	int          check_count = 0;
	int          n;

	always #2.5 clk = ~clk;

	sli_regs #(.SECOND_BRIDGE(1'b0)) dut (
		.CLK_SYS_I(clk), .ARST_N_I(arst_n), .CFG_RD_I(rd_s), .CFG_WR_I(wr_s),
		.CFG_ADDR_I(addr), .CFG_BE_I(be), .CFG_WDATA_I(wdata), .CFG_ACK_O(ack),
		.CFG_RDATA_O(rdata), .HOTPLUG_ENABLE_FIRST_BRIDGE_I(hp_a),
		.HOTPLUG_ENABLE_SECOND_BRIDGE_I(hp_b), .CTL_WR_I(ctl_wr), .CTL_HI_I(ctl_hi),
		.CTL_BE_I(ctl_be), .CTL_WDATA_I(ctl_wdata), .CTL_ENTRY_O(ctl_entry),
		.REMOTE_REQUEST_PENDING_SET_I(pend_set), .REMOTE_REQUEST_PENDING_CLR_I(pend_clr),
		.PACKET_INFO_BITS_O(info), .PASS_POSTED_WRITES_FLAG_O(pass_posted_writes_flag),
		.POLARITY_BIT_O(polarity_bit), .INTERRUPT_MASK_BIT_O(mask), .DS_READ_REQ_I(req),
		.DS_READ_DONE_I(done), .UP_BUF_FREE_I(free), .DS_READ_GRANT_O(grant));

	// second bridge shares all inputs; only its config answer is looked at
	sli_regs #(.SECOND_BRIDGE(1'b1)) dut_b (
		.CLK_SYS_I(clk), .ARST_N_I(arst_n), .CFG_RD_I(rd_s), .CFG_WR_I(wr_s),
		.CFG_ADDR_I(addr), .CFG_BE_I(be), .CFG_WDATA_I(wdata), .CFG_ACK_O(ack2),
		.CFG_RDATA_O(rdata2), .HOTPLUG_ENABLE_FIRST_BRIDGE_I(hp_a),
		.HOTPLUG_ENABLE_SECOND_BRIDGE_I(hp_b), .CTL_WR_I(ctl_wr), .CTL_HI_I(ctl_hi),
		.CTL_BE_I(ctl_be), .CTL_WDATA_I(ctl_wdata), .CTL_ENTRY_O(),
		.REMOTE_REQUEST_PENDING_SET_I(pend_set), .REMOTE_REQUEST_PENDING_CLR_I(pend_clr),
		.PACKET_INFO_BITS_O(), .PASS_POSTED_WRITES_FLAG_O(), .POLARITY_BIT_O(),
		.INTERRUPT_MASK_BIT_O(), .DS_READ_REQ_I(req), .DS_READ_DONE_I(done),
		.UP_BUF_FREE_I(free), .DS_READ_GRANT_O());

	// ***************************************************************
	// checking and closing
	// ***************************************************************
	task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	initial begin
		#100000;
		miscompares++;
		final_report();
	end

	// ***************************************************************
	// access tasks
	// ***************************************************************
	task automatic cfg(input logic w, input logic [7:0] a, input logic [3:0] b,
			input logic [31:0] d);
		@(posedge clk);
		rd_s  <= ~w;
		wr_s  <= w;
		addr  <= a;
		be    <= b;
		wdata <= d;
		@(posedge clk);
		rd_s <= 1'b0;
		wr_s <= 1'b0;
		#1;
		chk("ack", {ack, ack2}, 2'b11);
		q = rdata;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		cfg(1'b0, a, 4'h0, 32'h0);
		chk("rdata", q, exp);
	endtask

	// write then read on the very next cycle
	task automatic wr_rd(input logic [7:0] wa, input logic [3:0] b, input logic [31:0] d,
			input logic [7:0] ra, input logic [31:0] exp);
		@(posedge clk);
		rd_s  <= 1'b0;
		wr_s  <= 1'b1;
		addr  <= wa;
		be    <= b;
		wdata <= d;
		@(posedge clk);
		wr_s <= 1'b0;
		rd_s <= 1'b1;
		addr <= ra;
		be   <= 4'h0;
		@(posedge clk);
		rd_s <= 1'b0;
		#1;
		chk("b2b_ack", {ack, ack2}, 2'b11);
		chk("b2b_rdata", rdata, exp);
	endtask

	// reads one half of the entry through the data port
	task automatic rd_entry(input logic hi, input logic [31:0] exp);
		wr_rd(OFF_HDR, 4'b0100, {8'h00, hi ? IDX_ENTRY_HI : IDX_ENTRY_LO, 16'h0000},
			OFF_DATA, exp);
	endtask

	task automatic ctl(input logic hi, input logic [31:0] d);
		@(posedge clk);
		ctl_wr    <= 1'b1;
		ctl_hi    <= hi;
		ctl_be    <= 4'hf;
		ctl_wdata <= d;
		@(posedge clk);
		ctl_wr <= 1'b0;
		repeat (2) @(posedge clk);
	endtask

	task automatic count_grants(input int cycles);
		n = 0;
		repeat (cycles) begin
			@(posedge clk);
			#1;
			if (grant === 1'b1) n++;
		end
	endtask

	// ***************************************************************
	// main sequence
	// ***************************************************************
	initial begin
		repeat (10) @(posedge clk);
		arst_n <= 1'b1;
		#1;
		chk("entry_rst", ctl_entry, ENTRY_RST);
		chk("info_rst", info, 56'hf800_0000);
		chk("flags_rst", {pass_posted_writes_flag, polarity_bit, mask}, 3'b001);
		rd(OFF_SPLIT, {LIMIT_RST, RESP_CAPACITY});
		rd(OFF_HDR, {CAP_TYPE, INDEX_RST, NXT_LINK, CAP_ID});
		chk("hdr_b", rdata2, {CAP_TYPE, INDEX_RST, NXT_END, CAP_ID});
		cfg(1'b1, OFF_SPLIT, 4'hf, 32'h0020_5a5a);
		rd(OFF_SPLIT, {16'h0020, RESP_CAPACITY});
		wr_rd(OFF_SPLIT, 4'hf, 32'h0030_0000, OFF_SPLIT, {16'h0030, RESP_CAPACITY});
		wr_rd(OFF_SPLIT, 4'b0100, 32'h00ff_0000, OFF_SPLIT, {16'h00ff, RESP_CAPACITY});
		cfg(1'b1, OFF_HDR, 4'hf, 32'h0022_5555);
		@(posedge clk);
		hp_a <= 1'b1;
		hp_b <= 1'b1;
		rd(OFF_HDR, {CAP_TYPE, 8'h22, NXT_HOTPLUG, CAP_ID});
		chk("hdr_b_hp", rdata2, {CAP_TYPE, 8'h22, NXT_HOTPLUG, CAP_ID});
		rd(OFF_DATA, 32'h0);
		rd(8'h00, 32'h0);
		cfg(1'b1, OFF_DATA, 4'hf, 32'hdead_beef);
		rd_entry(1'b0, 32'hf800_0001);
		cfg(1'b1, OFF_DATA, 4'hf, 32'hdead_beef);
		rd(OFF_DATA, 32'hdead_beef);
		rd_entry(1'b1, 32'h0000_0000);
		cfg(1'b1, OFF_DATA, 4'hf, 32'hffff_ffff);
		rd(OFF_DATA, 32'h40ff_ffff);
		repeat (3) @(posedge clk);
		#1;
		chk("info", info, 56'hff_ffff_dead_beec);
		chk("pass_posted_writes_flag_pol_mask", {pass_posted_writes_flag, polarity_bit, mask}, 3'b111);
		chk("ctl_entry", ctl_entry, 64'h40ff_ffff_dead_beef);
		cfg(1'b1, OFF_DATA, 4'b0001, 32'h0);
		rd(OFF_DATA, 32'h40ff_ff00);
		ctl(1'b0, 32'h0000_01f2);
		rd_entry(1'b0, 32'h0000_01f2);
		chk("info_ctl", info[31:0], 32'h0000_01f0);
		chk("pol_mask", {polarity_bit, mask}, 2'b10);
		@(posedge clk);
		pend_set <= 1'b1;
		@(posedge clk);
		pend_set <= 1'b0;
		ctl(1'b1, 32'h0000_0000);
		rd_entry(1'b1, 32'h8000_0000);
		cfg(1'b1, OFF_DATA, 4'b1000, 32'h8000_0000);
		rd(OFF_DATA, 32'h0000_0000);
		@(posedge clk);
		pend_set <= 1'b1;
		pend_clr <= 1'b1;
		@(posedge clk);
		pend_set <= 1'b0;
		pend_clr <= 1'b0;
		rd(OFF_DATA, 32'h8000_0000);
		@(posedge clk);
		pend_clr <= 1'b1;
		@(posedge clk);
		pend_clr <= 1'b0;
		rd(OFF_DATA, 32'h0000_0000);
		ctl(1'b0, 32'h0000_001c);
		chk("mt", info[4:2], 3'b111);
		@(posedge clk);
		free <= 16'h0003;
		req  <= 1'b1;
		count_grants(6);
		chk("grants", n, 3);
		@(posedge clk);
		done <= 1'b1;
		@(posedge clk);
		done <= 1'b0;
		count_grants(4);
		chk("grants_after_done", n, 1);
		req <= 1'b0;
		final_report();
	end
endmodule
`default_nettype wire
